// ==== hdl/irq_scope_pkg.sv ====
package irq_scope_pkg;
  // ==========================================================
  // widths
  localparam int SCP_W = 8;
  localparam int DP_W = 8;
  localparam int CHAN_W = 8;
  localparam int DEV_NUM_W = 4;
  localparam int MISC_W = 8;
  localparam int STD_W = 16;
  // ==========================================================
  // reset values
  localparam logic [SCP_W-1:0] SCP_MASK_RST = 8'h00;
  localparam logic [DP_W-1:0] DP_MASK_RST = 8'h00;
  localparam logic [SCP_W-1:0] SCP_STATUS_RST = 8'h00;
  localparam logic [DP_W-1:0] DP_STATUS_RST = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_EN_RST = 8'h00;
  localparam logic [DEV_NUM_W-1:0] DEV_NUM_RST = 4'h0;
  localparam logic BANK_RST = 1'b0;
  localparam logic CLK_STOP_MODE_RST = 1'b0;
  localparam logic [MISC_W-1:0] MISC_RST = 8'h00;
  // standard masks come out of reset blocking every source
  localparam logic [STD_W-1:0] STD_MASK_RST = 16'hffff;
endpackage

// ==== hdl/irq_status_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_status_cell (
  // clock and reset (reset acts without the clock)
  input wire logic clk,
  input wire logic rst_n,
  // source and host access
  input wire logic src,
  input wire logic rd,
  input wire logic unmask,
  // state
  output logic status,
  output logic pend
);
  logic src_d_reg;
  logic status_reg;
  logic status_next;
  logic pend_reg;
  logic pend_next;
  wire src_rise = src & ~src_d_reg;

  // [RULE11] [RULE12] any source sets status
  // [RULE14] sticky until read with source gone
  assign status_next = src | (status_reg & ~rd);
  // [RULE15] a read drops the pending mark even if the source stays
  // [RULE16] unmasking a set bit re-arms it
  assign pend_next = src_rise | (unmask & status_reg) | (pend_reg & ~rd);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_d_reg <= 1'b0;
      status_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      src_d_reg <= src;
      status_reg <= status_next;
      pend_reg <= pend_next;
    end
  end

  assign status = status_reg;
  assign pend = pend_reg;
endmodule // irq_status_cell
`default_nettype wire

// ==== hdl/codec_irq_reset_scope.sv ====
// Summary of operation
// [RULE1] every reset, sync loss too, restores bus masks, bank, address, channel enables.
// [RULE2] bus interrupt status clears on hard resets, survives sync loss.
// [RULE3] other bus-side registers reset only by power-on or device hard reset.
// [RULE4] codec registers reset on device and bus hard reset, not sync loss.
// [RULE5] bus hard reset: bus reset, forced reset bit, or clock-stop exit; the code counts clock-stop exit only while clk_stop_mode_reg is set.
// [RULE6] all resets here act asynchronously, without waiting for a clock edge.
// [RULE7] bus control and port statuses fold into one general status output.
// [RULE8] manager software reads the status registers to find the source.
// [RULE9] bus interrupt mask bit set allows, cleared blocks the source.
// [RULE10] standard mask bit set blocks that event from the pin.
// [RULE11] unmasked event sets status and asserts the pin.
// [RULE12] masked event sets status, pin unchanged.
// [RULE13] pin stays asserted until every set, unmasked bit is read.
// [RULE14] status stays set until read and its condition is gone.
// [RULE15] read with condition present keeps bit but drops the pin.
// [RULE16] unmasking an already set bit asserts the pin.
// [RULE17] host reads status after enabling a path to flush start-up flags.
// [RULE18] event bits clear on read; condition bits stay while present.
// [RULE19] pin is active low, registered OR of set, unmasked bits.
`timescale 1ns/1ps
`default_nettype none
module codec_irq_reset_scope #(
  parameter int SCP_W = irq_scope_pkg::SCP_W,
  parameter int DP_W = irq_scope_pkg::DP_W,
  parameter int CHAN_W = irq_scope_pkg::CHAN_W,
  parameter int STD_W = irq_scope_pkg::STD_W
) (
  // clock and power-on / device hard reset
  input wire logic clk,
  input wire logic rst_n,
  // bus reset causes
  input wire logic bus_reset,
  input wire logic force_reset,
  input wire logic clk_stop_exit,
  input wire logic sync_loss,
  // bus-side configuration writes
  input wire logic sdw_cfg_wr,
  input wire logic [SCP_W-1:0] scp_mask_in,
  input wire logic [DP_W-1:0] dp_mask_in,
  input wire logic bank_in,
  input wire logic [irq_scope_pkg::DEV_NUM_W-1:0] dev_num_in,
  input wire logic [CHAN_W-1:0] chan_en_in,
  input wire logic clk_stop_mode_in,
  input wire logic [irq_scope_pkg::MISC_W-1:0] misc_in,
  // bus interrupt sources and write-one clear
  input wire logic [SCP_W-1:0] scp_evt,
  input wire logic [DP_W-1:0] dp_evt,
  input wire logic sdw_status_clr,
  input wire logic [SCP_W-1:0] scp_clr_bits,
  input wire logic [DP_W-1:0] dp_clr_bits,
  // standard interrupt sources and host access
  input wire logic [STD_W-1:0] std_src,
  input wire logic [STD_W-1:0] std_rd,
  input wire logic std_mask_wr,
  input wire logic [STD_W-1:0] std_mask_in,
  // bus-side register state
  output logic [SCP_W-1:0] scp_mask_reg,
  output logic [DP_W-1:0] dp_mask_reg,
  output logic bank_reg,
  output logic [irq_scope_pkg::DEV_NUM_W-1:0] dev_num_reg,
  output logic [CHAN_W-1:0] chan_en_reg,
  output logic clk_stop_mode_reg,
  output logic [irq_scope_pkg::MISC_W-1:0] misc_reg,
  output logic [SCP_W-1:0] scp_status_reg,
  output logic [DP_W-1:0] dp_status_reg,
  output logic sdw_gen_irq_reg,
  // standard interrupt state and pin
  output logic [STD_W-1:0] std_status_reg,
  output logic [STD_W-1:0] std_mask_reg,
  output logic irq_n_reg
);
  // ==========================================================
  // reset scopes
  // causes are treated as glitch-free levels from their own flops
  wire sdw_hard_rst;
  wire all_rst_n;
  wire codec_rst_n;
  // [RULE5] three causes of bus hard reset
  assign sdw_hard_rst = bus_reset | force_reset | (clk_stop_exit & clk_stop_mode_reg);
  // [RULE6] reset nets feed flop reset pins directly
  assign all_rst_n = rst_n & ~sdw_hard_rst & ~sync_loss;
  assign codec_rst_n = rst_n & ~sdw_hard_rst;

  // ==========================================================
  // registers cleared by every reset
  // [RULE1] masks, bank, device number, channel enables
  always_ff @(posedge clk or negedge all_rst_n) begin
    if (!all_rst_n) begin
      scp_mask_reg <= irq_scope_pkg::SCP_MASK_RST;
      dp_mask_reg <= irq_scope_pkg::DP_MASK_RST;
      bank_reg <= irq_scope_pkg::BANK_RST;
      dev_num_reg <= irq_scope_pkg::DEV_NUM_RST;
      chan_en_reg <= irq_scope_pkg::CHAN_EN_RST;
    end else if (sdw_cfg_wr) begin
      scp_mask_reg <= scp_mask_in;
      dp_mask_reg <= dp_mask_in;
      bank_reg <= bank_in;
      dev_num_reg <= dev_num_in;
      chan_en_reg <= chan_en_in;
    end
  end

  // ==========================================================
  // registers cleared only by power-on / device hard reset
  // [RULE3] the clock-stop selection must survive the reset it causes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_stop_mode_reg <= irq_scope_pkg::CLK_STOP_MODE_RST;
      misc_reg <= irq_scope_pkg::MISC_RST;
    end else if (sdw_cfg_wr) begin
      clk_stop_mode_reg <= clk_stop_mode_in;
      misc_reg <= misc_in;
    end
  end

  // ==========================================================
  // bus interrupt status, kept across sync loss
  wire [SCP_W-1:0] scp_status_next;
  wire [DP_W-1:0] dp_status_next;
  wire gen_irq_next;
  // new events win over a clear in the same cycle
  assign scp_status_next = scp_evt |
    (scp_status_reg & ~(scp_clr_bits & {SCP_W{sdw_status_clr}}));
  assign dp_status_next = dp_evt |
    (dp_status_reg & ~(dp_clr_bits & {DP_W{sdw_status_clr}}));
  // [RULE7] general status; [RULE9] mask set means allowed
  assign gen_irq_next = |(scp_status_reg & scp_mask_reg) | |(dp_status_reg & dp_mask_reg);

  // [RULE2] cleared by hard resets only
  always_ff @(posedge clk or negedge codec_rst_n) begin
    if (!codec_rst_n) begin
      scp_status_reg <= irq_scope_pkg::SCP_STATUS_RST;
      dp_status_reg <= irq_scope_pkg::DP_STATUS_RST;
      sdw_gen_irq_reg <= 1'b0;
    end else begin
      scp_status_reg <= scp_status_next;
      dp_status_reg <= dp_status_next;
      sdw_gen_irq_reg <= gen_irq_next;
    end
  end

  // ==========================================================
  // standard interrupts
  wire [STD_W-1:0] std_status;
  wire [STD_W-1:0] std_pend;
  wire [STD_W-1:0] std_unmask;
  wire pin_active;
  assign std_unmask = {STD_W{std_mask_wr}} & std_mask_reg & ~std_mask_in;
  // [RULE11] [RULE13] pin follows pending bits
  // [RULE10] [RULE19] set mask blocks, pin is OR of pending unmasked bits
  assign pin_active = |(std_pend & ~std_mask_reg);

  genvar gi;
  generate
    for (gi = 0; gi < STD_W; gi++) begin : g_cell
      // [RULE18] one cell serves both event and condition bits
      irq_status_cell u_cell (
        .clk(clk),
        .rst_n(codec_rst_n),
        .src(std_src[gi]),
        .rd(std_rd[gi]),
        .unmask(std_unmask[gi]),
        .status(std_status[gi]),
        .pend(std_pend[gi])
      );
    end
  endgenerate

  // [RULE4] codec-side state shares the hard-reset scope
  always_ff @(posedge clk or negedge codec_rst_n) begin
    if (!codec_rst_n) begin
      std_mask_reg <= irq_scope_pkg::STD_MASK_RST;
      std_status_reg <= '0;
      irq_n_reg <= 1'b1;
    end else begin
      if (std_mask_wr) begin
        std_mask_reg <= std_mask_in;
      end
      std_status_reg <= std_status;
      irq_n_reg <= ~pin_active;
    end
  end

  // ==========================================================
  // checks
  logic [STD_W-1:0] chk_src_d_reg;
  always_ff @(posedge clk or negedge codec_rst_n) begin
    if (!codec_rst_n) begin
      chk_src_d_reg <= '0;
    end else begin
      chk_src_d_reg <= std_src;
    end
  end
  wire unmasked_rise = |(std_src & ~chk_src_d_reg & ~std_mask_reg);

  sequence s_unmask_set;
    (std_mask_wr && |(std_mask_reg & ~std_mask_in & std_status)) ##1 !std_mask_wr;
  endsequence

  a_unmasked_evt_pin: assert property (@(posedge clk) disable iff (!codec_rst_n) // [RULE11]
    (unmasked_rise && !std_mask_wr) |-> ##2 !irq_n_reg)
    else $error("unmasked event did not assert pin");
  a_masked_evt_sets: assert property (@(posedge clk) disable iff (!codec_rst_n) // [RULE12]
    (std_src != '0) |=> ((std_status & $past(std_src)) == $past(std_src)))
    else $error("source did not set status");
  a_pin_until_read: assert property (@(posedge clk) disable iff (!codec_rst_n) // [RULE13]
    (pin_active && std_rd == '0 && !std_mask_wr) |-> ##1 pin_active ##1 !irq_n_reg)
    else $error("pin dropped before read");
  a_cond_read_keep: assert property (@(posedge clk) disable iff (!codec_rst_n) // [RULE15]
    (|(std_rd & std_src)) |=>
      ((std_status & $past(std_rd & std_src)) == $past(std_rd & std_src)) &&
      ((std_pend & $past(std_rd & std_src & chk_src_d_reg)) == '0))
    else $error("read with condition present mishandled");
  a_read_clears: assert property (@(posedge clk) disable iff (!codec_rst_n) // [RULE18]
    (|(std_rd & ~std_src)) |=> ((std_status & $past(std_rd & ~std_src)) == '0))
    else $error("read did not clear absent source");
  a_unmask_pin: assert property (@(posedge clk) disable iff (!codec_rst_n) // [RULE16]
    s_unmask_set |-> ##1 !irq_n_reg)
    else $error("unmasking set bit did not assert pin");
  a_gen_irq_raise: assert property (@(posedge clk) disable iff (!codec_rst_n) // [RULE7]
    (|(scp_status_reg & scp_mask_reg) || |(dp_status_reg & dp_mask_reg)) |=> sdw_gen_irq_reg)
    else $error("general status missed a source");
  a_gen_irq_block: assert property (@(posedge clk) disable iff (!all_rst_n) // [RULE9]
    (scp_mask_reg == '0 && dp_mask_reg == '0) |=> !sdw_gen_irq_reg)
    else $error("cleared mask did not block");
  a_sdw_set_wins: assert property (@(posedge clk) disable iff (!codec_rst_n) // [RULE2]
    (sdw_status_clr && |(scp_evt & scp_clr_bits)) |=>
      ((scp_status_reg & $past(scp_evt)) == $past(scp_evt)))
    else $error("clear beat a new event");
endmodule // codec_irq_reset_scope
`default_nettype wire

// ==== testbench/host_reader.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host side of the pin
  input wire logic en,
  input wire logic irq_n,
  input wire logic [15:0] status,
  output logic [15:0] rd
);
  // ==========================================================
  // service loop
  // read pending status
  // the pin lags the read by two cycles, so a bit may be read three times; that is harmless
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd <= '0;
    end else begin
      rd <= (en && !irq_n) ? status : '0;
    end
  end
endmodule // host_reader
`default_nettype wire

// ==== testbench/tb_codec_irq_reset_scope.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_codec_irq_reset_scope;
  // ==========================================================
  // stimulus and observation
  logic clk, rst_n, bus_reset, force_reset, clk_stop_exit, sync_loss, sdw_cfg_wr, bank_in;
  logic clk_stop_mode_in, sdw_status_clr, std_mask_wr, host_en;
  logic [7:0] scp_mask_in, dp_mask_in, chan_en_in, misc_in, scp_evt, dp_evt;
  logic [7:0] scp_clr_bits, dp_clr_bits, scp_mask_reg, dp_mask_reg, chan_en_reg, misc_reg;
  logic [7:0] scp_status_reg, dp_status_reg;
  logic [3:0] dev_num_in, dev_num_reg;
  logic bank_reg, clk_stop_mode_reg, sdw_gen_irq_reg, irq_n_reg;
  logic [15:0] std_src, tb_rd, host_rd, std_mask_in, std_status_reg, std_mask_reg, cond;
  int checked = 0;
  int bad_count = 0;
  int cycles = 0;
  codec_irq_reset_scope dut_u (
    .clk(clk), .rst_n(rst_n), .bus_reset(bus_reset), .force_reset(force_reset),
    .clk_stop_exit(clk_stop_exit), .sync_loss(sync_loss), .sdw_cfg_wr(sdw_cfg_wr),
    .scp_mask_in(scp_mask_in), .dp_mask_in(dp_mask_in), .bank_in(bank_in),
    .dev_num_in(dev_num_in), .chan_en_in(chan_en_in), .clk_stop_mode_in(clk_stop_mode_in),
    .misc_in(misc_in), .scp_evt(scp_evt), .dp_evt(dp_evt), .sdw_status_clr(sdw_status_clr),
    .scp_clr_bits(scp_clr_bits), .dp_clr_bits(dp_clr_bits), .std_src(std_src),
    .std_rd(tb_rd | host_rd), .std_mask_wr(std_mask_wr), .std_mask_in(std_mask_in),
    .scp_mask_reg(scp_mask_reg), .dp_mask_reg(dp_mask_reg), .bank_reg(bank_reg),
    .dev_num_reg(dev_num_reg), .chan_en_reg(chan_en_reg),
    .clk_stop_mode_reg(clk_stop_mode_reg), .misc_reg(misc_reg),
    .scp_status_reg(scp_status_reg), .dp_status_reg(dp_status_reg),
    .sdw_gen_irq_reg(sdw_gen_irq_reg), .std_status_reg(std_status_reg),
    .std_mask_reg(std_mask_reg), .irq_n_reg(irq_n_reg));
  host_reader host_u (.clk(clk), .rst_n(rst_n), .en(host_en), .irq_n(irq_n_reg),
    .status(std_status_reg), .rd(host_rd));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // closing and hang guard
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      bad_count++;
      complete_run();
    end
  end
  // ==========================================================
  // access tasks: each except cause and release_all returns settled, two edges after its request
  task automatic std_op(input logic [15:0] s, input logic [15:0] r);
    @(posedge clk);
    std_src <= s | cond;
    tb_rd <= r;
    @(posedge clk);
    std_src <= cond;
    tb_rd <= '0;
    @(posedge clk) #1;
  endtask
  task automatic mask(input logic [15:0] m);
    @(posedge clk);
    std_mask_wr <= 1'b1;
    std_mask_in <= m;
    @(posedge clk) std_mask_wr <= 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic cfg(input logic [7:0] m, input logic mode);
    @(posedge clk);
    sdw_cfg_wr <= 1'b1;
    scp_mask_in <= m;
    dp_mask_in <= m;
    bank_in <= 1'b1;
    dev_num_in <= 4'h5;
    chan_en_in <= 8'h3c;
    misc_in <= 8'ha5;
    clk_stop_mode_in <= mode;
    @(posedge clk) sdw_cfg_wr <= 1'b0;
    @(posedge clk) #1;
  endtask
  // events, with an optional write-one clear in the same cycle
  task automatic bev(input logic [7:0] e, input logic [7:0] c);
    @(posedge clk);
    scp_evt <= e;
    dp_evt <= e;
    sdw_status_clr <= |c;
    scp_clr_bits <= c;
    dp_clr_bits <= c;
    @(posedge clk);
    scp_evt <= '0;
    dp_evt <= '0;
    sdw_status_clr <= 1'b0;
    @(posedge clk) #1;
  endtask
  // raises one reset cause and returns before any further clock edge
  task automatic cause(input int k);
    @(posedge clk);
    bus_reset <= (k == 0);
    force_reset <= (k == 1);
    clk_stop_exit <= (k == 2);
    sync_loss <= (k == 3);
    #1;
  endtask
  task automatic release_all();
    @(posedge clk);
    {bus_reset, force_reset, clk_stop_exit, sync_loss} <= 4'h0;
    @(posedge clk) #1;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {rst_n, bus_reset, force_reset, clk_stop_exit, sync_loss, sdw_cfg_wr} = '0;
    {bank_in, clk_stop_mode_in, sdw_status_clr, std_mask_wr, host_en} = '0;
    {scp_mask_in, dp_mask_in, chan_en_in, misc_in, scp_evt, dp_evt} = '0;
    {scp_clr_bits, dp_clr_bits, dev_num_in, std_src, tb_rd, std_mask_in, cond} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk) #1;
    `CHK("std_mask", 16'hffff, std_mask_reg)
    `CHK("irq_n", 1'b1, irq_n_reg)
    mask(16'hfffe);
    std_op(16'h0002, 16'h0000);
    `CHK("std_status", 16'h0002, std_status_reg)
    `CHK("irq_n", 1'b1, irq_n_reg)
    std_op(16'h0001, 16'h0000);
    `CHK("std_status", 16'h0003, std_status_reg)
    `CHK("irq_n", 1'b0, irq_n_reg)
    std_op(16'h0000, 16'h0001);
    `CHK("std_status", 16'h0002, std_status_reg)
    `CHK("irq_n", 1'b1, irq_n_reg)
    mask(16'hfffc);
    `CHK("irq_n", 1'b0, irq_n_reg)
    @(posedge clk) host_en <= 1'b1;
    repeat (6) @(posedge clk);
    host_en <= 1'b0;
    #1;
    `CHK("std_status", 16'h0000, std_status_reg)
    `CHK("irq_n", 1'b1, irq_n_reg)
    mask(16'hfff8);
    cond = 16'h0004;
    std_op(16'h0000, 16'h0000);
    `CHK("irq_n", 1'b0, irq_n_reg)
    std_op(16'h0000, 16'h0004);
    `CHK("std_status", 16'h0004, std_status_reg)
    `CHK("irq_n", 1'b1, irq_n_reg)
    // the read above dropped the pending mark, so only the unmask can raise the pin
    mask(16'hfffc);
    `CHK("irq_n", 1'b1, irq_n_reg)
    mask(16'hfff8);
    `CHK("irq_n", 1'b0, irq_n_reg)
    cond = 16'h0000;
    std_op(16'h0010, 16'h0004);
    `CHK("std_status", 16'h0010, std_status_reg)
    `CHK("irq_n", 1'b1, irq_n_reg)
    cfg(8'h01, 1'b1);
    `CHK("bus_cfg", 21'h0278b, {dp_mask_reg, chan_en_reg, dev_num_reg, bank_reg})
    bev(8'h80, 8'h00);
    `CHK("scp_status", 8'h80, scp_status_reg)
    `CHK("gen_irq", 1'b0, sdw_gen_irq_reg)
    bev(8'h01, 8'h00);
    `CHK("gen_irq", 1'b1, sdw_gen_irq_reg)
    cause(3);
    `CHK("scp_mask", 8'h00, scp_mask_reg)
    `CHK("bus_cfg", 21'h0, {dp_mask_reg, chan_en_reg, dev_num_reg, bank_reg})
    release_all();
    `CHK("scp_status", 8'h81, scp_status_reg)
    `CHK("dp_status", 8'h81, dp_status_reg)
    `CHK("misc", 8'ha5, misc_reg)
    `CHK("std_state", 32'h0010fff8, {std_status_reg, std_mask_reg})
    // a new event outweighs a write-one clear of the same bit
    bev(8'h01, 8'h81);
    `CHK("sdw_status", 16'h0101, {scp_status_reg, dp_status_reg})
    bev(8'h00, 8'h01);
    `CHK("sdw_status", 16'h0000, {scp_status_reg, dp_status_reg})
    for (int k = 0; k < 3; k++) begin
      cfg(8'h01, 1'b1);
      bev(8'h01, 8'h00);
      cause(k);
      `CHK("scp_status", 8'h00, scp_status_reg)
      `CHK("std_mask", 16'hffff, std_mask_reg)
      `CHK("bus_cfg", 21'h0, {dp_mask_reg, chan_en_reg, dev_num_reg, bank_reg})
      release_all();
      `CHK("kept", 9'h14b, {misc_reg, clk_stop_mode_reg})
      `CHK("gen_irq", 1'b0, sdw_gen_irq_reg)
    end
    cfg(8'h01, 1'b0);
    bev(8'h01, 8'h00);
    cause(2);
    release_all();
    `CHK("scp_status", 8'h01, scp_status_reg)
    @(posedge clk) rst_n <= 1'b0;
    #1;
    `CHK("misc", 8'h00, misc_reg)
    complete_run();
  end
endmodule // tb_codec_irq_reset_scope
`default_nettype wire
